// ### core/sft_core.sv
// sft_core: transmit half of one bit-oriented serial channel.
// assumes TX_BIT_EN is a one-cycle pulse per transmit bit time and
// all inputs are synchronous to CLK_SYS.
`timescale 1ns/100ps
`default_nettype none

module sft_core (
    input  wire logic       CLK_SYS,
    input  wire logic       RESET_N,
    input  wire logic       TX_BIT_EN,
    input  wire logic [7:0] FLAG_PATTERN,
    input  wire logic       TX_ENABLE,
    input  wire logic [1:0] CHAR_LEN,
    input  wire logic       PARITY_EN,
    input  wire logic       PARITY_EVEN,
    input  wire logic       POLY_SEL,
    input  wire logic       CRC_PRESET_ONES,
    input  wire logic       CRC_GEN_EN,
    input  wire logic       ABORT_ON_UNDERRUN,
    input  wire logic       MARK_IDLE,
    input  wire logic       RTS_BIT,
    input  wire logic       AUTO_ENABLES,
    input  wire logic       CTS_PIN,
    input  wire logic       CMD_VALID,
    input  wire logic [1:0] CMD_CODE,
    input  wire logic       SEND_ABORT,
    input  wire logic       TX_WRITE,
    input  wire logic [7:0] TX_DATA,
    output logic            TX_BUF_EMPTY,
    output logic            TXD,
    output logic            RTS_N,
    output logic            CTS_STATUS,
    output logic            EOM_LATCH,
    output logic            EOM_SET
);

    // one crc step for one serial bit, lsb first
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b,
                                             input logic        sel);
        logic [15:0] poly;
        poly = sel ? sft_pkg::CRC_16_POLY : sft_pkg::CRC_CCITT_POLY;
        crc_step = (c[0] ^ b) ? ((c >> 1) ^ poly) : (c >> 1);
    endfunction : crc_step

    // five-bit mode: the first zero from the top marks the data width
    function automatic logic [3:0] marker_len(input logic [7:0] d);
        logic [3:0] n;
        logic       seen;
        n    = sft_pkg::BITS_FIVE;
        seen = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (!seen && !d[i]) begin
                seen = 1'b1;
                n    = 4'(i);
            end
        end
        if (n > sft_pkg::BITS_FIVE) begin
            n = sft_pkg::BITS_FIVE;
        end else if (n == 4'h0) begin
            n = 4'h1;
        end
        marker_len = n;
    endfunction : marker_len

    sft_pkg::sft_kind_t kind_reg;
    sft_pkg::sft_kind_t ld_kind;
    logic [8:0]  sr_reg;
    logic [4:0]  idx_reg;
    logic [4:0]  len_reg;
    logic [3:0]  dlen_reg;
    logic        in_frame_reg;
    logic        close_reg;
    logic        abort_pend_reg;
    logic        buf_full_reg;
    logic [7:0]  buf_data_reg;
    logic        eom_reg;
    logic        eom_set_reg;
    logic [15:0] crc_reg;
    logic [15:0] crc_sh_reg;
    logic [4:0]  pipe_reg;
    logic [2:0]  ones_reg;
    logic        rts_n_reg;
    logic        cts_reg;
    logic [8:0]  ld_sr;
    logic [4:0]  ld_len;
    logic [3:0]  ld_dlen;
    logic [3:0]  dlen;
    logic [8:0]  dmask;
    logic        par_bit;
    logic        tx_go;
    logic        stall;
    logic        advance;
    logic        boundary;
    logic        cur_bit;
    logic        stuffable;
    logic        load_data;
    logic        load_eom;
    logic        crc_take;
    logic [15:0] crc_next;

    // auto enables let cts gate the transmitter
    assign tx_go = TX_ENABLE && !(AUTO_ENABLES && CTS_PIN);

    // width sampled from the field as the buffer moves into the shifter
    always_comb begin
        unique case (CHAR_LEN)
            sft_pkg::LEN_FIVE:  dlen = marker_len(buf_data_reg);
            sft_pkg::LEN_SIX:   dlen = sft_pkg::BITS_SIX;
            sft_pkg::LEN_SEVEN: dlen = sft_pkg::BITS_SEVEN;
            sft_pkg::LEN_EIGHT: dlen = sft_pkg::BITS_EIGHT;
        endcase
    end

    // unused upper bits are masked off; parity covers data bits only
    assign dmask   = 9'((9'h001 << dlen) - 9'h001);
    assign par_bit = (^(buf_data_reg & dmask[7:0])) ^ !PARITY_EVEN;

    // what to load at the next character boundary, in priority order
    always_comb begin
        ld_kind   = sft_pkg::K_FLAG;
        ld_sr     = {1'b0, FLAG_PATTERN};
        ld_len    = sft_pkg::GROUP_BITS;
        ld_dlen   = 4'h0;
        load_data = 1'b0;
        load_eom  = 1'b0;
        if (abort_pend_reg) begin
            ld_kind = sft_pkg::K_ABORT;
            ld_sr   = sft_pkg::ONES_GROUP;
        end else if (close_reg) begin
            ld_kind = sft_pkg::K_FLAG;
        end else if (!tx_go) begin
            ld_kind = sft_pkg::K_MARK;
            ld_sr   = sft_pkg::ONES_GROUP;
        end else if (buf_full_reg) begin
            ld_kind   = sft_pkg::K_DATA;
            load_data = 1'b1;
            ld_dlen   = dlen;
            ld_sr     = (9'(buf_data_reg) & dmask)
                      | (PARITY_EN ? (9'(par_bit) << dlen) : 9'h000);
            ld_len    = 5'(dlen) + 5'(PARITY_EN);
        end else if (in_frame_reg && !eom_reg) begin
            load_eom = 1'b1;
            if (ABORT_ON_UNDERRUN) begin
                ld_kind = sft_pkg::K_ABORT;
                ld_sr   = sft_pkg::ONES_GROUP;
            end else begin
                ld_kind = sft_pkg::K_CRC;
                ld_len  = sft_pkg::CRC_BITS;
            end
        end else if (MARK_IDLE && !in_frame_reg) begin
            ld_kind = sft_pkg::K_MARK;
            ld_sr   = sft_pkg::ONES_GROUP;
        end
    end

    // serial bit presented by the shifter
    always_comb begin
        if (kind_reg == sft_pkg::K_CRC) begin
            // a disabled transmitter pads the crc slot from the flag
            cur_bit = tx_go ? crc_sh_reg[0]
                            : FLAG_PATTERN[idx_reg[2:0]];
        end else begin
            cur_bit = sr_reg[0];
        end
    end

    assign stuffable = (kind_reg == sft_pkg::K_DATA)
                    || (kind_reg == sft_pkg::K_CRC);
    assign stall    = (ones_reg == sft_pkg::STUFF_RUN);
    assign advance  = TX_BIT_EN && !stall;
    // abort cuts the current character short; disable does not
    assign boundary = (idx_reg == len_reg - 5'h01)
                   || (abort_pend_reg && kind_reg != sft_pkg::K_ABORT);

    // shift register and frame bookkeeping
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            kind_reg     <= sft_pkg::K_MARK;
            sr_reg       <= sft_pkg::ONES_GROUP;
            idx_reg      <= 5'h00;
            len_reg      <= sft_pkg::GROUP_BITS;
            dlen_reg     <= 4'h0;
            in_frame_reg <= 1'b0;
            close_reg    <= 1'b0;
        end else if (advance) begin
            if (boundary) begin
                kind_reg     <= ld_kind;
                sr_reg       <= ld_sr;
                idx_reg      <= 5'h00;
                len_reg      <= ld_len;
                dlen_reg     <= ld_dlen;
                in_frame_reg <= load_data;
                close_reg    <= load_eom;
            end else begin
                sr_reg  <= sr_reg >> 1;
                idx_reg <= idx_reg + 5'h01;
            end
        end
    end

    // crc step for the data bit leaving the shifter this bit time
    assign crc_take = advance && kind_reg == sft_pkg::K_DATA && CRC_GEN_EN
                   && idx_reg < 5'(dlen_reg);
    assign crc_next = crc_take ? crc_step(crc_reg, cur_bit, POLY_SEL)
                               : crc_reg;

    // crc generator: reset loads all ones, then preset only on command; runs over data bits
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            crc_reg    <= sft_pkg::CRC_RESET;
            crc_sh_reg <= sft_pkg::CRC_ZEROS;
        end else begin
            if (CMD_VALID && CMD_CODE == sft_pkg::CMD_RESET_TX_CRC) begin
                crc_reg <= CRC_PRESET_ONES ? sft_pkg::CRC_ONES
                                           : sft_pkg::CRC_ZEROS;
            end else if (crc_take) begin
                crc_reg <= crc_next;
            end
            // the far end expects the remainder inverted; the last data
            // bit is folded in on the same edge, so the updated value goes
            if (advance && boundary && ld_kind == sft_pkg::K_CRC) begin
                crc_sh_reg <= ~crc_next;
            end else if (advance && kind_reg == sft_pkg::K_CRC) begin
                crc_sh_reg <= crc_sh_reg >> 1;
            end
        end
    end

    // one-entry transmit buffer; a new write beats the load
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            buf_full_reg <= 1'b0;
            buf_data_reg <= 8'h00;
        end else begin
            if (TX_WRITE) begin
                buf_full_reg <= 1'b1;
                buf_data_reg <= TX_DATA;
            end else if (SEND_ABORT) begin
                buf_full_reg <= 1'b0;
            end else if (advance && boundary && load_data) begin
                buf_full_reg <= 1'b0;
            end
        end
    end

    // abort request waits for the next bit time
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            abort_pend_reg <= 1'b0;
        end else if (SEND_ABORT) begin
            abort_pend_reg <= 1'b1;
        end else if (advance && boundary) begin
            abort_pend_reg <= 1'b0;
        end
    end

    // end-of-message latch: hardware set beats the reset command
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            eom_reg     <= sft_pkg::EOM_RESET;
            eom_set_reg <= 1'b0;
        end else begin
            eom_set_reg <= 1'b0;
            if (advance && boundary && load_eom) begin
                eom_reg     <= 1'b1;
                eom_set_reg <= !eom_reg;
            end else if (CMD_VALID && CMD_CODE == sft_pkg::CMD_RESET_EOM) begin
                eom_reg <= 1'b0;
            end
        end
    end

    // zero inserter: five-stage delay line, zero after five data or crc ones
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            pipe_reg <= sft_pkg::PIPE_RESET;
            ones_reg <= 3'h0;
        end else if (TX_BIT_EN) begin
            pipe_reg <= {pipe_reg[3:0], stall ? 1'b0 : cur_bit};
            if (stall || !stuffable || !cur_bit) begin
                ones_reg <= 3'h0;
            end else begin
                ones_reg <= ones_reg + 3'h1;
            end
        end
    end

    // modem lines, registered so the pins are glitch free
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rts_n_reg <= 1'b1;
            cts_reg   <= 1'b0;
        end else begin
            rts_n_reg <= !RTS_BIT;
            cts_reg   <= CTS_PIN;
        end
    end

    assign TXD          = pipe_reg[sft_pkg::ZI_DELAY - 1];
    assign RTS_N        = rts_n_reg;
    assign CTS_STATUS   = cts_reg;
    assign EOM_LATCH    = eom_reg;
    assign EOM_SET      = eom_set_reg;
    assign TX_BUF_EMPTY = !buf_full_reg;

endmodule : sft_core

`default_nettype wire

// ### shared/sft_pkg.sv
// sft_pkg: constants and types for the sdlc frame transmitter.
// assumes one system clock; bit times arrive as enable pulses.
`default_nettype none

package sft_pkg;

    // control command codes on the two command bits
    localparam logic [1:0] CMD_NULL         = 2'h0;
    localparam logic [1:0] CMD_RESET_RX_CRC = 2'h1;
    localparam logic [1:0] CMD_RESET_TX_CRC = 2'h2;
    localparam logic [1:0] CMD_RESET_EOM    = 2'h3;

    // character length field codes
    localparam logic [1:0] LEN_FIVE  = 2'h0;
    localparam logic [1:0] LEN_SEVEN = 2'h1;
    localparam logic [1:0] LEN_SIX   = 2'h2;
    localparam logic [1:0] LEN_EIGHT = 2'h3;

    // bits per character for each length code
    localparam logic [3:0] BITS_FIVE  = 4'h5;
    localparam logic [3:0] BITS_SIX   = 4'h6;
    localparam logic [3:0] BITS_SEVEN = 4'h7;
    localparam logic [3:0] BITS_EIGHT = 4'h8;

    // crc polynomials, bit-reversed for lsb-first shifting
    localparam logic [15:0] CRC_CCITT_POLY = 16'h8408;
    localparam logic [15:0] CRC_16_POLY    = 16'ha001;
    localparam logic [15:0] CRC_ONES       = 16'hffff;
    localparam logic [15:0] CRC_ZEROS      = 16'h0000;
    localparam logic [15:0] CRC_RESET      = 16'hffff;

    // shifter lengths and patterns
    localparam logic [4:0] GROUP_BITS  = 5'h08;
    localparam logic [4:0] CRC_BITS    = 5'h10;
    localparam logic [8:0] ONES_GROUP  = 9'h0ff;

    // zero inserter: run length that forces a zero, and its delay
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam int         ZI_DELAY  = 5;

    // reset values
    localparam logic       EOM_RESET  = 1'b1;
    localparam logic [4:0] PIPE_RESET = 5'h1f;

    // what the shift register currently holds
    typedef enum logic [2:0] {
        K_MARK  = 3'b000,
        K_FLAG  = 3'b001,
        K_DATA  = 3'b010,
        K_CRC   = 3'b011,
        K_ABORT = 3'b100
    } sft_kind_t;

endpackage : sft_pkg

`default_nettype wire

// ### bench/sft_monitor.sv
// sft_monitor: port-level timing checks for sft_core.
// assumes it is bound to sft_core and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module sft_monitor (
    input wire logic       CLK_SYS,
    input wire logic       RESET_N,
    input wire logic       TX_BIT_EN,
    input wire logic       RTS_BIT,
    input wire logic       CTS_PIN,
    input wire logic       CMD_VALID,
    input wire logic [1:0] CMD_CODE,
    input wire logic       SEND_ABORT,
    input wire logic       TX_WRITE,
    input wire logic       TX_BUF_EMPTY,
    input wire logic       TXD,
    input wire logic       RTS_N,
    input wire logic       CTS_STATUS,
    input wire logic       EOM_LATCH,
    input wire logic       EOM_SET
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    // latch reset request and its answer; a same-cycle hardware set wins
    sequence eom_req_s;
        CMD_VALID && CMD_CODE == sft_pkg::CMD_RESET_EOM;
    endsequence
    sequence eom_low_s;
        !EOM_LATCH || EOM_SET;
    endsequence

    chk_rts_inverse: assert property (1'b1 |=> RTS_N == !$past(RTS_BIT))
        else $error("rts pin not inverse of control bit");
    chk_cts_status: assert property (1'b1 |=> CTS_STATUS == $past(CTS_PIN))
        else $error("cts status not following pin");
    chk_eom_reset: assert property (eom_req_s |=> eom_low_s)
        else $error("latch reset command ignored");
    chk_eom_pulse: assert property ($rose(EOM_LATCH) |-> EOM_SET)
        else $error("latch set without set pulse");
    chk_pulse_width: assert property (EOM_SET |-> EOM_LATCH ##1 !EOM_SET)
        else $error("set pulse wrong");
    chk_buf_fill: assert property (TX_WRITE |=> !TX_BUF_EMPTY)
        else $error("buffer not full after write");
    chk_abort_clear: assert property (SEND_ABORT && !TX_WRITE |-> ##[1:2] TX_BUF_EMPTY)
        else $error("abort left buffer full");
    chk_bit_step: assert property (!$past(TX_BIT_EN) |-> $stable(TXD))
        else $error("serial output moved off bit time");
    chk_load_edge: assert property ($rose(TX_BUF_EMPTY) |->
        $past(TX_BIT_EN) || $past(SEND_ABORT))
        else $error("buffer emptied off a bit time");
endmodule : sft_monitor

bind sft_core sft_monitor u_mon (.CLK_SYS, .RESET_N, .TX_BIT_EN, .RTS_BIT,
    .CTS_PIN, .CMD_VALID, .CMD_CODE, .SEND_ABORT, .TX_WRITE, .TX_BUF_EMPTY,
    .TXD, .RTS_N, .CTS_STATUS, .EOM_LATCH, .EOM_SET);

`default_nettype wire

// ### bench/sft_station.sv
// sft_station: remote station on the serial line.
// assumes it owns the bit clock and samples the line once per bit time.
`timescale 1ns/100ps
`default_nettype none

module sft_station (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        txd,
    input  wire logic        clr,
    output logic             bit_en,
    output logic [15:0]      hist,
    output logic [4:0]       max_run,
    output logic [15:0]      pre_flag
);
    logic [1:0]  div_reg;
    logic [4:0]  run_reg;
    logic [23:0] dstuf_reg;

    // bit clock every fourth cycle; a modem clock runs free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    assign bit_en = (div_reg == 2'h3);

    // lsb-first history and longest run of ones, saturating at 31
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist    <= 16'h0000;
            run_reg <= 5'h00;
            max_run <= 5'h00;
        end else if (clr) begin
            run_reg <= 5'h00;
            max_run <= 5'h00;
        end else if (bit_en) begin
            hist    <= {txd, hist[15:1]};
            run_reg <= !txd ? 5'h00 : run_reg + {4'h0, run_reg != 5'h1f};
            if (txd && run_reg >= max_run && run_reg != 5'h1f)
                max_run <= run_reg + 5'h01;
        end
    end

    // destuffed history; the sixteen bits before each flag that closes
    // something other than a flag are kept, so the crc can be read later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dstuf_reg <= 24'h000000;
            pre_flag  <= 16'h0000;
        end else if (bit_en && !(run_reg == 5'h05 && !txd)) begin
            dstuf_reg <= {txd, dstuf_reg[23:1]};
            if ({txd, dstuf_reg[23:17]} == 8'h7e
                && dstuf_reg[16:9] != 8'h7e)
                pre_flag <= dstuf_reg[16:1];
        end
    end
endmodule : sft_station

`default_nettype wire

// ### bench/sft_core_bench.sv
// sft_core_bench: directed tests of the frame transmitter.
// assumes the station model supplies the bit clock and watches TXD.
`timescale 1ns/100ps
`default_nettype none

module sft_core_bench;
    logic clk_sys = 1'b0, reset_n = 1'b0, tx_en = 1'b0, par_en = 1'b0;
    logic par_even = 1'b0, preset = 1'b1, crc_en = 1'b1, ab_ur = 1'b0;
    logic mark = 1'b0, rts = 1'b0, auto_en = 1'b0, cts = 1'b0;
    logic cmd_v = 1'b0, abort = 1'b0, wr = 1'b0, clr = 1'b0;
    logic [1:0] len = sft_pkg::LEN_EIGHT, code = sft_pkg::CMD_NULL;
    logic [7:0] data = 8'h00;
    logic bit_en, empty, txd, rts_n, cts_st, eom, eom_set;
    logic [15:0] hist, pre_flag;
    logic [4:0] max_run;
    int mismatches = 0, checks_done = 0, eom_sets = 0, cycles = 0;

    sft_core DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n), .TX_BIT_EN(bit_en),
        .FLAG_PATTERN(8'h7e), .TX_ENABLE(tx_en), .CHAR_LEN(len),
        .PARITY_EN(par_en), .PARITY_EVEN(par_even), .POLY_SEL(1'b0),
        .CRC_PRESET_ONES(preset), .CRC_GEN_EN(crc_en),
        .ABORT_ON_UNDERRUN(ab_ur), .MARK_IDLE(mark), .RTS_BIT(rts),
        .AUTO_ENABLES(auto_en), .CTS_PIN(cts), .CMD_VALID(cmd_v),
        .CMD_CODE(code), .SEND_ABORT(abort), .TX_WRITE(wr), .TX_DATA(data),
        .TX_BUF_EMPTY(empty), .TXD(txd), .RTS_N(rts_n),
        .CTS_STATUS(cts_st), .EOM_LATCH(eom), .EOM_SET(eom_set));
    sft_station u_sta (.clk(clk_sys), .rst_n(reset_n), .txd(txd),
        .clr(clr), .bit_en(bit_en), .hist(hist), .max_run(max_run),
        .pre_flag(pre_flag));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // set pulses counted; the cycle ceiling cuts a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (eom_set === 1'b1) eom_sets++;
        if (cycles == 30000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(input logic [15:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s %h vs %h", $time, what, seen, exp);
        end
    endtask : check
    // one-cycle strobes, raised and dropped on falling edges
    task automatic put(input logic [7:0] d);
        @(negedge clk_sys) {wr, data} = {1'b1, d};
        @(negedge clk_sys) wr = 1'b0;
    endtask : put
    task automatic cmd(input logic [1:0] c);
        @(negedge clk_sys) {cmd_v, code} = {1'b1, c};
        @(negedge clk_sys) cmd_v = 1'b0;
    endtask : cmd
    task automatic bits(input int n);
        repeat (n * 4) @(negedge clk_sys);
    endtask : bits
    function automatic logic has_flag(input logic [15:0] h);
        for (int i = 0; i < 9; i++) if (h[i+:8] == 8'h7e) return 1'b1;
        return 1'b0;
    endfunction : has_flag
    // reference crc: reflected ccitt over n bits, lsb first, sent inverted
    function automatic logic [15:0] crc_ref(input logic [7:0] d, input int n,
                                            input logic p);
        logic [15:0] c;
        c = p ? sft_pkg::CRC_ONES : sft_pkg::CRC_ZEROS;
        for (int i = 0; i < n; i++)
            c = (c[0] ^ d[i]) ? (c >> 1) ^ sft_pkg::CRC_CCITT_POLY : c >> 1;
        return ~c;
    endfunction : crc_ref
    // one crc-closed frame from a freshly preset generator
    task automatic crc_frame(input logic [1:0] l, input logic [7:0] d,
                             input int n, input logic p, e);
        {len, preset, crc_en} = {l, p, e};
        cmd(sft_pkg::CMD_RESET_TX_CRC);
        put(d);
        cmd(sft_pkg::CMD_RESET_EOM);
        bits(64);
        check(pre_flag, crc_ref(d, e ? n : 0, p), "crc value");
    endtask : crc_frame
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    initial begin
        int n;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        check({txd, rts_n, eom, empty, cts_st, eom_set}, 6'h3c, "reset");
        tx_en = 1'b1;
        cmd(sft_pkg::CMD_RESET_TX_CRC);
        bits(32);
        check(has_flag(hist), 1'b1, "flag idle");
        mark = 1'b1;
        bits(32);
        check(hist, 16'hffff, "mark idle");
        mark = 1'b0;
        bits(24);
        $display("test idle done");
        put(8'ha5);
        bits(48);
        check(eom_sets, 0, "latch set frame");
        check(has_flag(hist), 1'b1, "closing flag");
        crc_frame(sft_pkg::LEN_EIGHT, 8'hc3, 8, 1'b1, 1'b1);
        crc_frame(sft_pkg::LEN_FIVE, 8'hf1, 3, 1'b0, 1'b1);
        crc_frame(sft_pkg::LEN_EIGHT, 8'h5a, 8, 1'b0, 1'b0);
        crc_en = 1'b1;
        $display("test crc done");
        // each length code, parity on the odd codes; each closes with crc
        for (int l = 0; l < 4; l++) begin
            {len, par_en, par_even} = {l[1:0], l[0], l[1]};
            n = eom_sets;
            put(8'h3c);
            cmd(sft_pkg::CMD_RESET_EOM);
            check(eom, 1'b0, "latch reset");
            bits(64);
            check({eom, empty}, 2'h3, "crc close");
            check(eom_sets, n + 1, "set pulses");
        end
        len = sft_pkg::LEN_EIGHT;
        par_en = 1'b0;
        $display("test frames done");
        {ab_ur, clr} = 2'h3;
        put(8'h00);
        clr = 1'b0;
        cmd(sft_pkg::CMD_RESET_EOM);
        bits(64);
        check(max_run >= 5'h08, 1'b1, "underrun abort");
        ab_ur = 1'b0;
        put(8'h00);
        for (int i = 0; i < 400 && empty !== 1'b1; i++) @(negedge clk_sys);
        // a second byte waits in the buffer when the abort arrives
        put(8'h00);
        clr = 1'b1;
        @(negedge clk_sys) {clr, abort} = 2'h1;
        @(negedge clk_sys) abort = 1'b0;
        @(negedge clk_sys);
        check(empty, 1'b1, "abort empties");
        bits(40);
        check(max_run >= 5'h08 && max_run <= 5'h0d, 1'b1, "abort ones");
        $display("test abort done");
        {auto_en, cts, rts} = 3'h7;
        bits(32);
        check(hist, 16'hffff, "cts off");
        check({cts_st, rts_n}, 2'h2, "modem pins");
        {auto_en, cts, rts} = 3'h0;
        reset_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        check({eom, empty, txd}, 3'h7, "second reset");
        $display("test modem done");
        summarize();
    end
endmodule : sft_core_bench

`default_nettype wire
